// ### hw/watchdog_reset_flag_pkg.sv
// shared constants, register map and carrier types of the watchdog with reset-cause flags
// assumes a 25 MHz system clock and a 128 kHz oscillator sampled as a plain pin
package watchdog_reset_flag_pkg;

  // register map, byte addresses on the AXI4-Lite bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h60;
  localparam logic [ADDR_W-1:0] RCF_ADDR = 8'h64;

  // watchdog_control field positions
  localparam int CTRL_IF_BIT = 7;
  localparam int CTRL_IE_BIT = 6;
  localparam int CTRL_P3_BIT = 5;
  localparam int CTRL_CE_BIT = 4;
  localparam int CTRL_RE_BIT = 3;
  localparam int CTRL_PLO_MSB = 2;

  // reset_cause_flags field positions
  localparam int RCF_DBG_BIT = 4;
  localparam int RCF_WD_BIT = 3;
  localparam int RCF_BO_BIT = 2;
  localparam int RCF_PIN_BIT = 1;
  localparam int RCF_POR_BIT = 0;
  localparam int RCF_W = 5;

  // reset values
  localparam logic [RCF_W-1:0] RCF_RESET = 5'h01;
  localparam logic [3:0] PRESC_RESET = 4'h0;

  // timing
  localparam int unsigned SYS_CLK_HZ = 25000000;
  localparam int unsigned OSC_FREQ_HZ = 128000;
  localparam int unsigned OSC_PERIOD_CLKS = SYS_CLK_HZ / OSC_FREQ_HZ;
  localparam logic [2:0] CE_WINDOW_CYCLES = 3'h4;
  localparam int unsigned TIMEOUT_BASE_CYCLES = 2048;
  localparam logic [3:0] PRESC_MAX_CODE = 4'h9;
  localparam int CNT_W = 21;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [0:0] {
    WATCHDOG_RESET_FLAG_WR_IDLE = 1'b0,
    WATCHDOG_RESET_FLAG_WR_RESP = 1'b1
  } watchdog_reset_flag_wr_e;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } watchdog_reset_flag_axil_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } watchdog_reset_flag_axil_rsp_s;

  typedef struct packed {
    logic pin;
    logic brownout;
    logic debug;
  } watchdog_reset_flag_rst_src_s;

  // last count of a time-out period; reserved codes behave as the longest one
  function automatic logic [CNT_W-1:0] timeout_last(input logic [3:0] code, input int unsigned base);
    logic [3:0] c;
    c = (code > PRESC_MAX_CODE) ? PRESC_MAX_CODE : code;
    return CNT_W'((base << c) - 1);
  endfunction : timeout_last

endpackage : watchdog_reset_flag_pkg

// ### hw/watchdog_reset_flag_osc_sync.sv
// oscillator pin synchroniser and rising-edge tick
// assumes the oscillator is far slower than clk
`timescale 1ns/1ps
module watchdog_reset_flag_osc_sync (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // oscillator pin and tick
  input wire logic osc_pin,
  output logic tick
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic tick;
  } watchdog_reset_flag_sync_state_s;

  watchdog_reset_flag_sync_state_s st;
  watchdog_reset_flag_sync_state_s next_st;

  // s1 feeds only s2
  always_comb
  begin
    next_st = st;
    next_st.s1 = osc_pin;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.tick = st.s2 && !st.s3;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

  AST_TICK_SINGLE: assert property (@(posedge clk) disable iff (reset) st.tick |=> !st.tick)
    else $error("oscillator tick longer than one cycle");

endmodule : watchdog_reset_flag_osc_sync

// ### hw/watchdog_reset_flag_timeout_counter.sv
// watchdog counter advancing on oscillator ticks, with selectable time-out
// assumes tick is a one-cycle pulse on clk
`timescale 1ns/1ps
module watchdog_reset_flag_timeout_counter #(
  parameter int unsigned BASE = watchdog_reset_flag_pkg::TIMEOUT_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] code,
  // result
  output logic timeout,
  output logic [watchdog_reset_flag_pkg::CNT_W-1:0] count
);

  typedef struct packed {
    logic [watchdog_reset_flag_pkg::CNT_W-1:0] count;
    logic timeout;
  } watchdog_reset_flag_cnt_state_s;

  watchdog_reset_flag_cnt_state_s st;
  watchdog_reset_flag_cnt_state_s next_st;
  logic [watchdog_reset_flag_pkg::CNT_W-1:0] last;

  assign last = watchdog_reset_flag_pkg::timeout_last(code, BASE);

  // a shorter period chosen mid-count fires at the next tick, not after wrapping
  always_comb
  begin
    next_st = st;
    next_st.timeout = 1'b0;
    if (restart || !run)
      next_st.count = '0;
    else if (tick)
    begin
      if (st.count >= last)
      begin
        next_st.count = '0;
        next_st.timeout = 1'b1;
      end
      else
        next_st.count = st.count + 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  assign timeout = st.timeout;
  assign count = st.count;

  AST_RESTART_CLEARS: assert property (@(posedge clk) disable iff (reset) restart |=> st.count == '0)
    else $error("restart did not clear the counter");
  AST_TIMEOUT_AT_LAST: assert property (@(posedge clk) disable iff (reset)
    st.timeout |-> $past(st.count) >= $past(last))
    else $error("time-out before the selected count");

endmodule : watchdog_reset_flag_timeout_counter

// ### hw/watchdog_reset_flag_watchdog_top.sv
// watchdog timer with reset-cause flags, AXI4-Lite register slave
// assumes cpu-side inputs and reset-source events are on clk; reset is power-on reset
// Contract
// - counter runs on 128 kHz oscillator, times out
// - restart instruction clears counter to zero
// - mode from fuse, reset and interrupt enables
// - fuse locks reset enable one, interrupt zero
// - vector entry clears flag, and enable only when reset is enabled
// - unserviced second time-out applies system reset
// - new values accepted within four cycles only
// - flag set on time-out, cleared by vector/one
// - interrupt needs global, enable and flag
// - control register bit layout and reset values
// - reset-cause bits seven to five read zero
// - debug-port reset flag at bit four
// - watchdog reset flag at bit three
// - brown-out reset flag at bit two
// - pin reset flag at bit one
// - power-on flag cleared only by writing zero
// - prescaler selects 2K to 1024K cycles
// - change enable self-clears after four cycles
// - watchdog flag forces reset enable set
// - watchdog reset is one-cycle pulse
`timescale 1ns/1ps
module watchdog_reset_flag_watchdog_top #(
  parameter int unsigned TIMEOUT_BASE = watchdog_reset_flag_pkg::TIMEOUT_BASE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register bus
  input watchdog_reset_flag_pkg::watchdog_reset_flag_axil_req_s axil_req,
  output watchdog_reset_flag_pkg::watchdog_reset_flag_axil_rsp_s axil_rsp,
  // oscillator pin
  input wire logic osc_128k,
  // cpu side
  input wire logic always_on_fuse,
  input wire logic cpu_global_int_en,
  input wire logic restart_exec,
  input wire logic irq_vector_ack,
  // reset sources
  input watchdog_reset_flag_pkg::watchdog_reset_flag_rst_src_s reset_sources,
  // results
  output logic timeout_irq,
  output logic watchdog_system_reset
);

  typedef struct packed {
    watchdog_reset_flag_pkg::watchdog_reset_flag_wr_e wphase;
    logic aw_held;
    logic w_held;
    logic [watchdog_reset_flag_pkg::ADDR_W-1:0] awaddr;
    logic [7:0] wbyte;
    logic wstrb0;
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic fuse_q;
    logic timeout_interrupt_flag;
    logic timeout_interrupt_enable;
    logic reset_enable_bit;
    logic [3:0] wdp;
    logic [2:0] ce_cnt;
    logic [watchdog_reset_flag_pkg::RCF_W-1:0] rcf;
    logic irq;
    logic sysrst;
  } watchdog_reset_flag_top_state_s;

  watchdog_reset_flag_top_state_s st;
  watchdog_reset_flag_top_state_s next_st;

  logic tick;
  logic timeout;
  logic [watchdog_reset_flag_pkg::CNT_W-1:0] count;
  logic wde_eff;
  logic ce_open;
  logic run;
  logic ctrl_wr;
  logic rcf_wr;
  logic wd_fire;
  logic reinit;
  logic any_source;
  logic [7:0] ctrl_rd;

  watchdog_reset_flag_osc_sync u_sync (
    .clk(clk),
    .reset(reset),
    .osc_pin(osc_128k),
    .tick(tick)
  );

  watchdog_reset_flag_timeout_counter #(
    .BASE(TIMEOUT_BASE)
  ) u_counter (
    .clk(clk),
    .reset(reset),
    .tick(tick),
    .run(run),
    .restart(restart_exec || reinit),
    .code(st.wdp),
    .timeout(timeout),
    .count(count)
  );

  // the watchdog flag and the fuse both keep reset enable alive
  assign wde_eff = st.reset_enable_bit || st.rcf[watchdog_reset_flag_pkg::RCF_WD_BIT] || st.fuse_q;
  assign ce_open = st.ce_cnt != 3'h0;
  assign run = wde_eff || st.timeout_interrupt_enable;
  assign any_source = reset_sources.pin || reset_sources.brownout || reset_sources.debug;
  assign wd_fire = timeout && wde_eff && (!st.timeout_interrupt_enable || st.timeout_interrupt_flag);
  assign reinit = wd_fire || any_source;
  assign ctrl_rd = {st.timeout_interrupt_flag, st.timeout_interrupt_enable, st.wdp[3], ce_open, wde_eff, st.wdp[2:0]};

  always_comb
  begin
    next_st = st;
    ctrl_wr = 1'b0;
    rcf_wr = 1'b0;

    // read channel: one read at a time, data held until rready
    if (st.rvalid && axil_req.rready)
      next_st.rvalid = 1'b0;
    if (st.arready && axil_req.arvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp = watchdog_reset_flag_pkg::RESP_OKAY;
      case (axil_req.araddr)
        watchdog_reset_flag_pkg::CTRL_ADDR: next_st.rdata = {24'h000000, ctrl_rd};
        watchdog_reset_flag_pkg::RCF_ADDR: next_st.rdata = {24'h000000, 3'h0, st.rcf};
        default:
        begin
          next_st.rdata = 32'h00000000;
          next_st.rresp = watchdog_reset_flag_pkg::RESP_DECERR;
        end
      endcase
    end
    next_st.arready = !next_st.rvalid;

    // write channel: address and data taken in either order
    if (st.awready && axil_req.awvalid)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr = axil_req.awaddr;
    end
    if (st.wready && axil_req.wvalid)
    begin
      next_st.w_held = 1'b1;
      next_st.wbyte = axil_req.wdata[7:0];
      next_st.wstrb0 = axil_req.wstrb[0];
    end
    case (st.wphase)
      watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_IDLE:
      begin
        if (st.aw_held && st.w_held)
        begin
          next_st.wphase = watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_RESP;
          next_st.aw_held = 1'b0;
          next_st.w_held = 1'b0;
          next_st.bresp = watchdog_reset_flag_pkg::RESP_OKAY;
          ctrl_wr = (st.awaddr == watchdog_reset_flag_pkg::CTRL_ADDR) && st.wstrb0;
          rcf_wr = (st.awaddr == watchdog_reset_flag_pkg::RCF_ADDR) && st.wstrb0;
          if (st.awaddr != watchdog_reset_flag_pkg::CTRL_ADDR && st.awaddr != watchdog_reset_flag_pkg::RCF_ADDR)
            next_st.bresp = watchdog_reset_flag_pkg::RESP_DECERR;
        end
      end
      watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_RESP:
      begin
        if (axil_req.bready)
          next_st.wphase = watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_IDLE;
      end
      default: next_st.wphase = watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_IDLE;
    endcase
    next_st.awready = !next_st.aw_held && (next_st.wphase == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_IDLE);
    next_st.wready = !next_st.w_held && (next_st.wphase == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_IDLE);

    // change window counts down on its own, reopening restarts it
    next_st.fuse_q = always_on_fuse;
    if (ce_open)
      next_st.ce_cnt = st.ce_cnt - 3'h1;

    if (ctrl_wr)
    begin
      if (st.wbyte[watchdog_reset_flag_pkg::CTRL_IF_BIT])
        next_st.timeout_interrupt_flag = 1'b0;
      next_st.timeout_interrupt_enable = st.wbyte[watchdog_reset_flag_pkg::CTRL_IE_BIT];
      if (st.wbyte[watchdog_reset_flag_pkg::CTRL_CE_BIT] && st.wbyte[watchdog_reset_flag_pkg::CTRL_RE_BIT])
      begin
        next_st.ce_cnt = watchdog_reset_flag_pkg::CE_WINDOW_CYCLES;
        next_st.reset_enable_bit = 1'b1;
      end
      else if (ce_open && !st.wbyte[watchdog_reset_flag_pkg::CTRL_CE_BIT])
      begin
        next_st.reset_enable_bit = st.wbyte[watchdog_reset_flag_pkg::CTRL_RE_BIT];
        next_st.wdp = {st.wbyte[watchdog_reset_flag_pkg::CTRL_P3_BIT], st.wbyte[watchdog_reset_flag_pkg::CTRL_PLO_MSB:0]};
      end
      else if (st.wbyte[watchdog_reset_flag_pkg::CTRL_RE_BIT])
        next_st.reset_enable_bit = 1'b1;
    end

    // writing zero clears a cause flag, writing one leaves it
    if (rcf_wr)
      next_st.rcf = st.rcf & st.wbyte[watchdog_reset_flag_pkg::RCF_W-1:0];

    // vector entry; in interrupt-then-reset it drops back to plain reset mode
    if (irq_vector_ack)
    begin
      next_st.timeout_interrupt_flag = 1'b0;
      if (wde_eff)
        next_st.timeout_interrupt_enable = 1'b0;
    end

    // hardware sets come after the clears so a coincident event is kept
    if (timeout && st.timeout_interrupt_enable && !wd_fire)
      next_st.timeout_interrupt_flag = 1'b1;
    next_st.sysrst = wd_fire;
    if (wd_fire)
      next_st.rcf[watchdog_reset_flag_pkg::RCF_WD_BIT] = 1'b1;
    if (reset_sources.pin)
      next_st.rcf[watchdog_reset_flag_pkg::RCF_PIN_BIT] = 1'b1;
    if (reset_sources.brownout)
      next_st.rcf[watchdog_reset_flag_pkg::RCF_BO_BIT] = 1'b1;
    if (reset_sources.debug)
      next_st.rcf[watchdog_reset_flag_pkg::RCF_DBG_BIT] = 1'b1;

    // a system reset returns the control register to its initial state, cause flags survive
    if (reinit)
    begin
      next_st.timeout_interrupt_flag = 1'b0;
      next_st.timeout_interrupt_enable = 1'b0;
      next_st.reset_enable_bit = 1'b0;
      next_st.wdp = watchdog_reset_flag_pkg::PRESC_RESET;
      next_st.ce_cnt = 3'h0;
    end

    if (st.fuse_q)
    begin
      next_st.reset_enable_bit = 1'b1;
      next_st.timeout_interrupt_enable = 1'b0;
    end

    next_st.irq = cpu_global_int_en && next_st.timeout_interrupt_enable && next_st.timeout_interrupt_flag;
  end

  // power-on reset clears every flag but the power-on one
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st <= '0;
      st.rcf <= watchdog_reset_flag_pkg::RCF_RESET;
    end
    else
      st <= next_st;
  end

  assign axil_rsp.awready = st.awready;
  assign axil_rsp.wready = st.wready;
  assign axil_rsp.bvalid = (st.wphase == watchdog_reset_flag_pkg::WATCHDOG_RESET_FLAG_WR_RESP);
  assign axil_rsp.bresp = st.bresp;
  assign axil_rsp.arready = st.arready;
  assign axil_rsp.rvalid = st.rvalid;
  assign axil_rsp.rdata = st.rdata;
  assign axil_rsp.rresp = st.rresp;
  assign timeout_irq = st.irq;
  assign watchdog_system_reset = st.sysrst;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_SYSRST_PULSE: assert property (st.sysrst |=> !st.sysrst)
    else $error("watchdog reset wider than one cycle");
  AST_SYSRST_FLAG: assert property (st.sysrst |-> st.rcf[watchdog_reset_flag_pkg::RCF_WD_BIT] && ctrl_rd[watchdog_reset_flag_pkg::CTRL_RE_BIT])
    else $error("watchdog reset without its flag");
  AST_FUSE_LOCK: assert property (st.fuse_q |=> st.reset_enable_bit && !st.timeout_interrupt_enable)
    else $error("fuse did not lock the enables");
  AST_CE_COUNTDOWN: assert property (ce_open && !ctrl_wr && !reinit
    |=> st.ce_cnt == $past(st.ce_cnt) - 3'h1)
    else $error("change window did not count down");
  AST_PRESC_LOCKED: assert property (ctrl_wr && !ce_open && !reinit |=> st.wdp == $past(st.wdp))
    else $error("prescaler changed outside the window");
  AST_WATCHDOG_RESET_FLAG_FORCES_RE: assert property (st.rcf[watchdog_reset_flag_pkg::RCF_WD_BIT] |-> ctrl_rd[watchdog_reset_flag_pkg::CTRL_RE_BIT])
    else $error("reset enable reads clear while watchdog flag set");
  AST_IRQ_GATE: assert property (st.irq |-> st.timeout_interrupt_enable && st.timeout_interrupt_flag && $past(cpu_global_int_en))
    else $error("interrupt without all three enables");
  AST_RESET_MODE: assert property (timeout && wde_eff && !st.timeout_interrupt_enable |=> st.sysrst)
    else $error("reset mode time-out gave no reset");
  AST_SECOND_TIMEOUT: assert property (timeout && wde_eff && st.timeout_interrupt_enable && st.timeout_interrupt_flag |=> st.sysrst)
    else $error("unserviced second time-out gave no reset");
  AST_ACK_CLEARS: assert property (irq_vector_ack && wde_eff && !timeout && !st.fuse_q && !ctrl_wr
    |=> !st.timeout_interrupt_enable && !st.timeout_interrupt_flag)
    else $error("vector entry left enable or flag set");
  AST_RCF_RESERVED: assert property (st.rvalid |-> st.rdata[31:8] == 24'h000000)
    else $error("reserved bits read nonzero");
  AST_INT_MODE: assert property (timeout && !wde_eff && st.timeout_interrupt_enable && !reinit
    |=> st.timeout_interrupt_flag && !st.sysrst)
    else $error("interrupt mode time-out did not set flag");

  // counter, window, interrupt and cause flags; a reset source in the same cycle reinitialises control
  AST_STOPPED_HOLDS: assert property (!run
    |=> count == '0)
    else $error("stopped watchdog counter moved");
  AST_RCF_READ_ZERO: assert property (st.arready && axil_req.arvalid && axil_req.araddr == watchdog_reset_flag_pkg::RCF_ADDR
    |=> st.rdata[7:5] == 3'h0)
    else $error("reserved cause bits read nonzero");
  AST_OPEN_WINDOW: assert property (ctrl_wr && !reinit
    && st.wbyte[watchdog_reset_flag_pkg::CTRL_CE_BIT] && st.wbyte[watchdog_reset_flag_pkg::CTRL_RE_BIT]
    |=> st.ce_cnt == watchdog_reset_flag_pkg::CE_WINDOW_CYCLES)
    else $error("opening write did not open the window");
  AST_WINDOW_LOADS: assert property (ctrl_wr && ce_open && !st.wbyte[watchdog_reset_flag_pkg::CTRL_CE_BIT] && !reinit
    |=> st.wdp == {$past(st.wbyte[watchdog_reset_flag_pkg::CTRL_P3_BIT]), $past(st.wbyte[watchdog_reset_flag_pkg::CTRL_PLO_MSB:0])})
    else $error("window write did not load the prescaler");
  AST_VECTOR_FLAG: assert property (irq_vector_ack && !timeout
    |=> !st.timeout_interrupt_flag)
    else $error("vector entry left the flag set");
  AST_POWER_ON_RESET_FLAG_STICKY: assert property (!rcf_wr
    |=> st.rcf[watchdog_reset_flag_pkg::RCF_POR_BIT] == $past(st.rcf[watchdog_reset_flag_pkg::RCF_POR_BIT]))
    else $error("power-on flag changed without a software write");
  AST_WD_FLAG_SET: assert property (wd_fire
    |=> st.rcf[watchdog_reset_flag_pkg::RCF_WD_BIT])
    else $error("watchdog reset left its flag clear");
  AST_PIN_FLAG_SET: assert property (reset_sources.pin
    |=> st.rcf[watchdog_reset_flag_pkg::RCF_PIN_BIT])
    else $error("pin reset left its flag clear");
  AST_BO_FLAG_SET: assert property (reset_sources.brownout
    |=> st.rcf[watchdog_reset_flag_pkg::RCF_BO_BIT])
    else $error("brown-out reset left its flag clear");
  AST_DBG_FLAG_SET: assert property (reset_sources.debug
    |=> st.rcf[watchdog_reset_flag_pkg::RCF_DBG_BIT])
    else $error("debug-port reset left its flag clear");

  COV_TIMEOUT_IRQ: cover property (st.irq);
  COV_WD_RESET: cover property (st.sysrst);
  COV_CHANGE_SEQ: cover property (ce_open && ctrl_wr && !st.wbyte[watchdog_reset_flag_pkg::CTRL_CE_BIT]);
  COV_ACK: cover property (irq_vector_ack && st.timeout_interrupt_enable && wde_eff);
  COV_FUSE_RESET: cover property (st.fuse_q && st.sysrst);

endmodule : watchdog_reset_flag_watchdog_top

// ### test/watchdog_reset_flag_watchdog_top_tb.sv
// self-checking bench for the watchdog with reset-cause flags
// assumes TIMEOUT_BASE of 4 and an oscillator of 8 clk periods made here
`timescale 1ns/1ps
module watchdog_reset_flag_watchdog_top_tb;
  localparam logic [7:0] CA = watchdog_reset_flag_pkg::CTRL_ADDR;
  localparam logic [7:0] FA = watchdog_reset_flag_pkg::RCF_ADDR;
  logic clk = 1'b0;
  logic reset = 1'b1;
  watchdog_reset_flag_pkg::watchdog_reset_flag_axil_req_s req = '0;
  watchdog_reset_flag_pkg::watchdog_reset_flag_axil_rsp_s rsp;
  watchdog_reset_flag_pkg::watchdog_reset_flag_rst_src_s srcs = '0;
  logic osc = 1'b0;
  logic osc_run = 1'b0;
  logic [1:0] div = 2'h0;
  logic fuse = 1'b0;
  logic gie = 1'b0;
  logic restart = 1'b0;
  logic ack = 1'b0;
  logic irq;
  logic sysrst;
  logic [31:0] rd;
  logic [1:0] resp;
  int mismatches = 0;
  int checks_done = 0;
  int rst_cnt = 0;
  int n;
  int n0;

  watchdog_reset_flag_watchdog_top #(.TIMEOUT_BASE(4)) DUT (.clk(clk), .reset(reset), .axil_req(req), .axil_rsp(rsp),
    .osc_128k(osc), .always_on_fuse(fuse), .cpu_global_int_en(gie), .restart_exec(restart),
    .irq_vector_ack(ack), .reset_sources(srcs), .timeout_irq(irq), .watchdog_system_reset(sysrst));

  always #20 clk = ~clk;

  // oscillator freezes while stopped, so register work cannot race a time-out
  always @(posedge clk)
  begin
    div <= div + 2'h1;
    if (osc_run && div == 2'h3)
      osc <= ~osc;
    if (sysrst === 1'b1)
      rst_cnt <= rst_cnt + 1;
  end

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{awvalid: 1'b1, awaddr: a, wvalid: 1'b1, wdata: {24'h0, d}, wstrb: 4'hf, bready: 1'b1, default: '0};
    do
    begin
      @(posedge clk);
      if (rsp.awready === 1'b1)
        req.awvalid <= 1'b0;
      if (rsp.wready === 1'b1)
        req.wvalid <= 1'b0;
    end
    while (req.awvalid || req.wvalid);
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [7:0] a);
    @(posedge clk);
    req <= '{arvalid: 1'b1, araddr: a, rready: 1'b1, default: '0};
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
  endtask : rdr

  // full word compared, so upper and reserved bits must read zero
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rdr(a);
    chk(rd, {24'h0, exp});
  endtask : rdc

  task automatic src(input watchdog_reset_flag_pkg::watchdog_reset_flag_rst_src_s s);
    @(posedge clk);
    srcs <= s;
    @(posedge clk);
    srcs <= '0;
  endtask : src

  task automatic kick;
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask : kick

  task automatic wait_irq;
    do @(posedge clk); while (irq !== 1'b1);
  endtask : wait_irq

  task automatic wait_rst(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while (sysrst !== 1'b1);
    @(posedge clk);
    chk(sysrst, 1'b0);
  endtask : wait_rst

  task automatic t_reset_and_flags;
    rdc(CA, 8'h00);
    rdc(FA, 8'h01);
    rdr(8'h68);
    chk(resp, watchdog_reset_flag_pkg::RESP_DECERR);
    wr(FA, 8'h00);
    rdc(FA, 8'h00);
    src('{pin: 1'b1, default: 1'b0});
    rdc(FA, 8'h02);
    src('{brownout: 1'b1, default: 1'b0});
    rdc(FA, 8'h06);
    src('{debug: 1'b1, default: 1'b0});
    rdc(FA, 8'h16);
    wr(FA, 8'hfd);
    rdc(FA, 8'h14);
    wr(FA, 8'h00);
    rdc(FA, 8'h00);
  endtask : t_reset_and_flags

  task automatic t_irq_mode;
    wr(CA, 8'h40);
    osc_run <= 1'b1;
    repeat (50) @(posedge clk);
    osc_run <= 1'b0;
    rdc(CA, 8'hc0);
    chk(irq, 1'b0);
    gie <= 1'b1;
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(CA, 8'hc0);
    rdc(CA, 8'h40);
    chk(irq, 1'b0);
    wr(CA, 8'h80);
    osc_run <= 1'b1;
    repeat (80) @(posedge clk);
    osc_run <= 1'b0;
    rdc(CA, 8'h00);
    chk(rst_cnt, 0);
  endtask : t_irq_mode

  task automatic t_window;
    wr(CA, 8'h08);
    wr(CA, 8'h01);
    rdc(CA, 8'h08);
    wr(CA, 8'h18);
    rdc(CA, 8'h18);
    repeat (6) @(posedge clk);
    wr(CA, 8'h01);
    rdc(CA, 8'h08);
    kick();
    wr(CA, 8'h18);
    wr(CA, 8'h2f);
    rdc(CA, 8'h2f);
    wr(CA, 8'h18);
    wr(CA, 8'h09);
    rdc(CA, 8'h09);
    kick();
    osc_run <= 1'b1;
    wait_rst(n);
    osc_run <= 1'b0;
    chk(n >= 48 && n <= 72, 1'b1);
    rdc(FA, 8'h08);
    rdc(CA, 8'h08);
    wr(CA, 8'h18);
    wr(CA, 8'h00);
    rdc(CA, 8'h08);
  endtask : t_window

  task automatic t_restart;
    n0 = rst_cnt;
    osc_run <= 1'b1;
    repeat (10)
    begin
      kick();
      repeat (14) @(posedge clk);
    end
    osc_run <= 1'b0;
    chk(rst_cnt, n0);
  endtask : t_restart

  task automatic t_int_then_reset;
    wr(FA, 8'h00);
    rdc(CA, 8'h00);
    wr(CA, 8'h48);
    n0 = rst_cnt;
    kick();
    osc_run <= 1'b1;
    wait_irq();
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rdc(CA, 8'h08);
    chk(rst_cnt, n0);
    wr(CA, 8'h48);
    wait_irq();
    wait_rst(n);
    osc_run <= 1'b0;
    chk(n >= 28 && n <= 36, 1'b1);
  endtask : t_int_then_reset

  task automatic t_fuse;
    fuse <= 1'b1;
    repeat (3) @(posedge clk);
    wr(CA, 8'h40);
    rdc(CA, 8'h08);
    osc_run <= 1'b1;
    wait_rst(n);
    osc_run <= 1'b0;
    chk(irq, 1'b0);
    chk(n <= 40, 1'b1);
  endtask : t_fuse

  initial
  begin
    #400000;
    mismatches++;
    close_out();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_reset_and_flags();
    t_irq_mode();
    t_window();
    t_restart();
    t_int_then_reset();
    t_fuse();
    close_out();
  end
endmodule : watchdog_reset_flag_watchdog_top_tb
